// [core/tsa_pkg.sv]
/*
 * tsa_pkg: register offsets, field positions, reset values, tag codes and
 * timing constants of the slope alarm block.
 * Assumes a 100 MHz system clock and 8-bit register offsets on the serial bus.
 */
package tsa_pkg;
   // register offsets (byte addresses on the serial interface)
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_EN = 8'h02;
   localparam logic [7:0] REG_FIFO_DATA = 8'h08;
   localparam logic [7:0] REG_PIN_CFG = 8'h12;
   localparam logic [7:0] REG_ALARM_HI_H = 8'h22;
   localparam logic [7:0] REG_ALARM_HI_L = 8'h23;
   localparam logic [7:0] REG_ALARM_LO_H = 8'h24;
   localparam logic [7:0] REG_ALARM_LO_L = 8'h25;
   localparam logic [7:0] REG_RISE_LIM = 8'h26;
   localparam logic [7:0] REG_FALL_LIM = 8'h27;
   localparam logic [7:0] REG_FILT_CFG = 8'h28;
   localparam logic [7:0] REG_MODE = 8'h2A;
   localparam logic [7:0] REG_SLOPE_H = 8'h2D;
   localparam logic [7:0] REG_SLOPE_L = 8'h2E;
   // field positions
   localparam int ST_RISE_BIT = 4;
   localparam int ST_FALL_BIT = 5;
   localparam int FILT_EN_BIT = 3;
   localparam int EXT_EN_BIT = 7;
   localparam int EXT_EDGE_BIT = 6;
   localparam int AUTO_BIT = 1;
   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [15:0] ALARM_HI_RST = 16'h7FFF;
   localparam logic [15:0] ALARM_LO_RST = 16'h8000;
   localparam logic [6:0] I2C_ADDR_RST = 7'h40;
   // tag codes
   localparam logic [1:0] CT_AUTO = 2'h1;
   localparam logic [1:0] CT_EXT = 2'h2;
   localparam logic [1:0] CODE_NORMAL = 2'h0;
   localparam logic [1:0] CODE_RISE_LOW = 2'h2;
   localparam logic [1:0] CODE_FALL_HIGH = 2'h3;
   localparam logic [23:0] INVALID_WORD = 24'hFFFFFF;
   // sizes
   localparam int FIFO_DEPTH = 64;
   localparam int WORD_W = 24;
   localparam int HIST_DEPTH = 64;
   localparam logic [6:0] WIN_MAX = 7'h41;
   // timing: fastest autonomous sample period
   localparam int SYS_CLK_MHZ = 100;
   localparam int AUTO_PERIOD_MS = 125;
   localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_MS * SYS_CLK_MHZ * 1000;
   // serial target states
   typedef enum logic [3:0] {
      I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_WDATA, I_WACK, I_RDATA, I_MACK
   } tsa_i2c_st_t;
endpackage

// [core/tsa_core.sv]
/*
 * tsa_core: temperature slope alarm with tagged result FIFO and serial target.
 * Also holds tsa_fifo, the result buffer.
 * Assumes: samples arrive from the converter on adc_clk with a one-cycle
 * adc_valid, spaced far apart (milliseconds); scl/sda are open-drain pins
 * resolved outside; the host keeps three-byte bursts on the FIFO data register.
 */
`timescale 1ns/1ps

module tsa_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 64
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire empty = (wr_r == rd_r);
   wire push = in_valid & ~full;
   wire pop = out_ready & ~empty;

   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rd_r[AW-1:0]];

   // storage has no reset; only pointers carry state
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r[AW-1:0]] <= in_data;
      end
   end

   // extra pointer bit tells full from empty
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_r + (AW+1)'(push);
         rd_r <= rd_r + (AW+1)'(pop);
      end
   end
endmodule

module tsa_core #(
   parameter logic [6:0] DEV_ADDR = tsa_pkg::I2C_ADDR_RST,
   parameter int AUTO_PERIOD_CYC = tsa_pkg::AUTO_PERIOD_CYC,
   parameter int FIFO_DEPTH = tsa_pkg::FIFO_DEPTH
) (
   // clocks and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic adc_clk,
   // converter front end
   input wire logic adc_valid,
   input wire logic [15:0] adc_data,
   output logic conv_req,
   // pins
   input wire logic external_convert_input,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq_b
);
   import tsa_pkg::*;

   // converter domain: hold the sample and flag it with a toggle
   logic [15:0] adc_hold_r;
   logic adc_tog_r;
   always_ff @(posedge adc_clk or negedge rst_b) begin
      if (!rst_b) begin
         adc_hold_r <= 16'h0000;
         adc_tog_r <= 1'b0;
      end else if (adc_valid) begin
         adc_hold_r <= adc_data;
         adc_tog_r <= ~adc_tog_r;
      end
   end

   // synchronisers: bit 0 feeds bit 1 only, bits 1/2 give level and edge
   logic [2:0] tog_sync_r;
   logic [2:0] scl_sync_r;
   logic [2:0] sda_sync_r;
   logic [2:0] trig_sync_r;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tog_sync_r <= 3'h0;
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         trig_sync_r <= 3'h7; // convert pin idles high: no false edge at release
      end else begin
         tog_sync_r <= {tog_sync_r[1:0], adc_tog_r};
         scl_sync_r <= {scl_sync_r[1:0], scl};
         sda_sync_r <= {sda_sync_r[1:0], sda_in};
         trig_sync_r <= {trig_sync_r[1:0], external_convert_input};
      end
   end
   wire sample_evt = tog_sync_r[2] ^ tog_sync_r[1];
   wire scl_s = scl_sync_r[1];
   wire sda_s = sda_sync_r[1];
   wire scl_rise = scl_s & ~scl_sync_r[2];
   wire scl_fall = ~scl_s & scl_sync_r[2];
   wire i2c_start = scl_s & scl_sync_r[2] & sda_sync_r[2] & ~sda_s;
   wire i2c_stop = scl_s & scl_sync_r[2] & ~sda_sync_r[2] & sda_s;

   // configuration registers
   logic [7:0] ien_r;
   logic [7:0] pin_cfg_r;
   logic [15:0] alarm_hi_r;
   logic [15:0] alarm_lo_r;
   logic [7:0] rise_lim_r;
   logic [7:0] fall_lim_r;
   logic [7:0] filt_cfg_r;
   logic [7:0] mode_r;
   wire auto_en = mode_r[AUTO_BIT];
   wire ext_en = pin_cfg_r[EXT_EN_BIT];
   wire det_en = filt_cfg_r[FILT_EN_BIT] & (auto_en | ext_en);
   wire [2:0] win_code = filt_cfg_r[2:0];

   // triggers: autonomous timer or chosen edge of the convert pin
   logic [31:0] auto_cnt_r;
   logic conv_req_r;
   logic [1:0] ctype_r;
   wire auto_tick = auto_en & (auto_cnt_r == 32'(AUTO_PERIOD_CYC - 1));
   wire trig_rise = trig_sync_r[1] & ~trig_sync_r[2];
   wire trig_fall = ~trig_sync_r[1] & trig_sync_r[2];
   wire ext_evt = ext_en & (pin_cfg_r[EXT_EDGE_BIT] ? trig_rise : trig_fall);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         auto_cnt_r <= 32'h00000000;
         conv_req_r <= 1'b0;
         ctype_r <= CT_AUTO;
      end else begin
         auto_cnt_r <= (auto_en & ~auto_tick) ? auto_cnt_r + 32'h00000001 : 32'h00000000;
         conv_req_r <= auto_tick | ext_evt;
         if (auto_tick | ext_evt) begin
            ctype_r <= ext_evt ? CT_EXT : CT_AUTO;
         end
      end
   end

   // slope datapath: window N-1 is a power of two, so the divide is a shift
   logic [15:0] hist [HIST_DEPTH];
   logic [5:0] hptr_r;
   logic [6:0] cnt_r;
   logic [8:0] slope_r;
   logic pend_vld_r;
   logic [23:0] pend_word_r;
   wire sample_go = sample_evt & ~pend_vld_r; // a sample is lost while the FIFO stalls
   wire [2:0] shift_k = (win_code >= 3'h6) ? 3'h6 : win_code;
   wire [6:0] span = 7'h01 << shift_k;
   wire [6:0] nsamp = span + 7'h01;
   wire [15:0] oldest = hist[hptr_r - span[5:0]];
   wire signed [16:0] diff = $signed({adc_hold_r[15], adc_hold_r}) -
                             $signed({oldest[15], oldest});
   wire signed [16:0] sl_full = diff >>> shift_k;
   wire sat_hi = sl_full > 17'sh000FF;
   wire sat_lo = sl_full < 17'sh1FF00;
   wire [8:0] slope9 = sat_hi ? 9'h0FF : (sat_lo ? 9'h100 : sl_full[8:0]);
   wire win_ok = (cnt_r + 7'h01) >= nsamp;
   wire slope_ok = det_en & win_ok;
   wire slope_upd = sample_go & slope_ok;
   wire signed [9:0] slope_x = $signed({slope9[8], slope9});
   wire signed [9:0] rise_x = $signed({2'b00, rise_lim_r});
   wire signed [9:0] fall_x = -$signed({2'b00, fall_lim_r});
   wire rise_hit = slope_x > rise_x;
   wire fall_hit = slope_x < fall_x;
   wire [1:0] rcode = ~slope_ok ? CODE_NORMAL :
                      (rise_hit ? CODE_RISE_LOW : (fall_hit ? CODE_FALL_HIGH : CODE_NORMAL));
   wire [1:0] tcode = ($signed(adc_hold_r) > $signed(alarm_hi_r)) ? CODE_FALL_HIGH :
                      (($signed(adc_hold_r) < $signed(alarm_lo_r)) ? CODE_RISE_LOW :
                      CODE_NORMAL);
   wire [15:0] word_data = rcode[1] ? {{7{slope9[8]}}, slope9} : adc_hold_r;
   wire [23:0] word_nxt = {1'b0, ctype_r, rcode, tcode, 1'b1, word_data};

   // history ring always records; the count restarts whenever detection is off
   always_ff @(posedge sys_clk) begin
      if (sample_go) begin
         hist[hptr_r] <= adc_hold_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hptr_r <= 6'h00;
         cnt_r <= 7'h00;
         slope_r <= 9'h000;
      end else begin
         hptr_r <= hptr_r + 6'(sample_go);
         if (!det_en) begin
            cnt_r <= 7'h00;
         end else if (sample_go && cnt_r != WIN_MAX) begin
            cnt_r <= cnt_r + 7'h01;
         end
         if (slope_upd) begin
            slope_r <= slope9;
         end
      end
   end

   // result word waits here until the FIFO takes it
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [23:0] fifo_out_data;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_vld_r <= 1'b0;
         pend_word_r <= 24'h000000;
      end else if (sample_go) begin
         pend_vld_r <= 1'b1;
         pend_word_r <= word_nxt;
      end else if (fifo_in_ready) begin
         pend_vld_r <= 1'b0;
      end
   end

   tsa_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .rst_b(rst_b),
      .in_valid(pend_vld_r),
      .in_ready(fifo_in_ready),
      .in_data(pend_word_r),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // serial target state
   tsa_i2c_st_t ist_r;
   logic [3:0] bitc_r;
   logic [7:0] shr_r;
   logic rw_r;
   logic [7:0] ptr_r;
   logic [1:0] fbyte_r;
   logic sda_oe_r;
   logic st_rise_r;
   logic st_fall_r;
   logic irq_b_r;

   // read decode: FIFO bytes go tag first, empty FIFO reads the invalid word
   wire [23:0] fifo_word = fifo_out_valid ? fifo_out_data : INVALID_WORD;
   wire [7:0] fifo_byte = (fbyte_r == 2'h0) ? fifo_word[23:16] :
                          ((fbyte_r == 2'h1) ? fifo_word[15:8] : fifo_word[7:0]);
   wire [7:0] status_byte = (8'(st_rise_r) << ST_RISE_BIT) | (8'(st_fall_r) << ST_FALL_BIT);
   wire [7:0] rd_byte =
      (ptr_r == REG_STATUS) ? status_byte :
      (ptr_r == REG_IRQ_EN) ? ien_r :
      (ptr_r == REG_FIFO_DATA) ? fifo_byte :
      (ptr_r == REG_PIN_CFG) ? pin_cfg_r :
      (ptr_r == REG_ALARM_HI_H) ? alarm_hi_r[15:8] :
      (ptr_r == REG_ALARM_HI_L) ? alarm_hi_r[7:0] :
      (ptr_r == REG_ALARM_LO_H) ? alarm_lo_r[15:8] :
      (ptr_r == REG_ALARM_LO_L) ? alarm_lo_r[7:0] :
      (ptr_r == REG_RISE_LIM) ? rise_lim_r :
      (ptr_r == REG_FALL_LIM) ? fall_lim_r :
      (ptr_r == REG_FILT_CFG) ? filt_cfg_r :
      (ptr_r == REG_MODE) ? mode_r :
      (ptr_r == REG_SLOPE_H) ? {7'h00, slope_r[8]} :
      (ptr_r == REG_SLOPE_L) ? slope_r[7:0] : 8'h00;
   wire rd_ld = scl_fall & (((ist_r == I_AACK) & rw_r) | (ist_r == I_MACK));
   wire at_fifo = (ptr_r == REG_FIFO_DATA);
   wire [7:0] ptr_adv = at_fifo ? ptr_r : ptr_r + 8'h01; // burst stays on the FIFO
   wire [1:0] fbyte_adv = (at_fifo && fbyte_r != 2'h2) ? fbyte_r + 2'h1 : 2'h0;
   assign fifo_pop = rd_ld & at_fifo & (fbyte_r == 2'h2);
   wire wr_stb = scl_fall & (ist_r == I_WDATA) & (bitc_r == 4'h8);
   wire st_clr = rd_ld & (ptr_r == REG_STATUS);
   wire addr_ok = (shr_r[7:1] == DEV_ADDR);

   // serial target: sample on scl rise, drive on scl fall
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ist_r <= I_IDLE;
         bitc_r <= 4'h0;
         shr_r <= 8'h00;
         rw_r <= 1'b0;
         ptr_r <= 8'h00;
         fbyte_r <= 2'h0;
         sda_oe_r <= 1'b0;
      end else if (i2c_start) begin
         ist_r <= I_ADDR;
         bitc_r <= 4'h0;
         fbyte_r <= 2'h0;
         sda_oe_r <= 1'b0;
      end else if (i2c_stop) begin
         ist_r <= I_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         case (ist_r)
            I_ADDR, I_REG, I_WDATA: begin
               if (scl_rise) begin
                  shr_r <= {shr_r[6:0], sda_s};
                  bitc_r <= bitc_r + 4'h1;
               end else if (scl_fall && bitc_r == 4'h8) begin
                  bitc_r <= 4'h0;
                  sda_oe_r <= (ist_r != I_ADDR) | addr_ok;
                  if (ist_r == I_ADDR) begin
                     rw_r <= shr_r[0];
                     ist_r <= addr_ok ? I_AACK : I_IDLE;
                  end else if (ist_r == I_REG) begin
                     ptr_r <= shr_r;
                     fbyte_r <= 2'h0;
                     ist_r <= I_RACK;
                  end else begin
                     ist_r <= I_WACK;
                  end
               end
            end
            I_AACK, I_MACK: begin
               if (ist_r == I_MACK && scl_rise && sda_s) begin
                  ist_r <= I_IDLE; // host ended the read with a not-acknowledge
               end else if (rd_ld) begin
                  shr_r <= rd_byte;
                  sda_oe_r <= ~rd_byte[7];
                  bitc_r <= 4'h1;
                  ptr_r <= ptr_adv;
                  fbyte_r <= fbyte_adv;
                  ist_r <= I_RDATA;
               end else if (scl_fall) begin
                  sda_oe_r <= 1'b0;
                  ist_r <= I_REG;
               end
            end
            I_RACK, I_WACK: begin
               if (scl_fall) begin
                  sda_oe_r <= 1'b0;
                  ptr_r <= (ist_r == I_WACK) ? ptr_r + 8'h01 : ptr_r;
                  ist_r <= I_WDATA;
               end
            end
            I_RDATA: begin
               if (scl_fall && bitc_r == 4'h8) begin
                  sda_oe_r <= 1'b0;
                  ist_r <= I_MACK;
               end else if (scl_fall) begin
                  sda_oe_r <= ~shr_r[6];
                  shr_r <= {shr_r[6:0], 1'b0};
                  bitc_r <= bitc_r + 4'h1;
               end
            end
            default: begin
               ist_r <= I_IDLE;
            end
         endcase
      end
   end

   // writable registers; other offsets ignore writes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ien_r <= CFG_RST;
         pin_cfg_r <= CFG_RST;
         alarm_hi_r <= ALARM_HI_RST;
         alarm_lo_r <= ALARM_LO_RST;
         rise_lim_r <= CFG_RST;
         fall_lim_r <= CFG_RST;
         filt_cfg_r <= CFG_RST;
         mode_r <= CFG_RST;
      end else if (wr_stb) begin
         if (ptr_r == REG_IRQ_EN) ien_r <= shr_r;
         if (ptr_r == REG_PIN_CFG) pin_cfg_r <= shr_r;
         if (ptr_r == REG_ALARM_HI_H) alarm_hi_r[15:8] <= shr_r;
         if (ptr_r == REG_ALARM_HI_L) alarm_hi_r[7:0] <= shr_r;
         if (ptr_r == REG_ALARM_LO_H) alarm_lo_r[15:8] <= shr_r;
         if (ptr_r == REG_ALARM_LO_L) alarm_lo_r[7:0] <= shr_r;
         if (ptr_r == REG_RISE_LIM) rise_lim_r <= shr_r;
         if (ptr_r == REG_FALL_LIM) fall_lim_r <= shr_r;
         if (ptr_r == REG_FILT_CFG) filt_cfg_r <= shr_r;
         if (ptr_r == REG_MODE) mode_r <= shr_r;
      end
   end

   // sticky flags: a set in the clearing cycle survives the clear
   wire irq_any = (st_rise_r & ien_r[ST_RISE_BIT]) | (st_fall_r & ien_r[ST_FALL_BIT]);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_rise_r <= 1'b0;
         st_fall_r <= 1'b0;
         irq_b_r <= 1'b1;
      end else begin
         st_rise_r <= (slope_upd & rise_hit) | (st_rise_r & ~st_clr);
         st_fall_r <= (slope_upd & fall_hit) | (st_fall_r & ~st_clr);
         irq_b_r <= ~irq_any;
      end
   end

   assign conv_req = conv_req_r;
   assign sda_oe = sda_oe_r;
   assign sda_out = 1'b0; // open drain: only ever pulls low
   assign irq_b = irq_b_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_det_off_hold: assert property (!det_en |=> $stable(slope_r))
      else $error("slope changed while detection disabled");
   a_slope_store: assert property (slope_upd |=> slope_r == $past(slope9))
      else $error("slope register missed an update");
   a_rise_flag: assert property (slope_upd && rise_hit |=> st_rise_r
      ##1 (st_rise_r || $past(st_clr)))
      else $error("rise flag not set and held");
   a_fall_flag: assert property (slope_upd && fall_hit |=> st_fall_r)
      else $error("fall flag not set");
   a_irq_gated: assert property (
      !(st_rise_r && ien_r[ST_RISE_BIT]) && !(st_fall_r && ien_r[ST_FALL_BIT]) |=> irq_b_r)
      else $error("interrupt asserted without an enabled flag");
   a_read_clear: assert property (st_clr && !slope_upd |=>
      !st_rise_r && !st_fall_r ##1 irq_b_r)
      else $error("status read did not clear flags and interrupt");
   a_window_len: assert property (win_code == 3'h4 |-> nsamp == 7'h11)
      else $error("window length wrong for code 4");
   a_no_early: assert property (sample_go && det_en && cnt_r == 7'h00 && win_code != 3'h0
      |=> $stable(slope_r))
      else $error("slope stored before window filled");
   a_tag_shape: assert property (sample_go |=> !pend_word_r[23] && pend_word_r[16])
      else $error("temperature tag framing bits wrong");
   a_fast_word: assert property (sample_go && rcode[1] |=> pend_word_r[8:0] == slope_r)
      else $error("too-fast word does not carry the slope");
endmodule

// [testbench/tsa_host_model.sv]
/* tsa_host_model: serial bus host that writes and reads the block's registers.
   Assumes the bench resolves sda with a pull-up and the target sits at DEV_ADDR. */
`timescale 1ns/1ps
module tsa_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h40
) (
   // clock
   input wire logic clk,
   // bus
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   int nack_cnt = 0;

   // idle bus: both lines released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // 8 clocks a quarter bit keeps each scl phase far above the 4-cycle minimum
   task automatic wt;
      repeat (8) @(posedge clk);
   endtask

   // one bit slot; the target's level is taken in mid high phase
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      wt();
      sda_low <= ~b;
      wt();
      scl <= 1'b1;
      wt();
      r = sda;
      wt();
   endtask

   // a=0 gives a start (also repeated), a=1 a stop
   task automatic cond(input logic a);
      scl <= 1'b0;
      wt();
      sda_low <= a;
      wt();
      scl <= 1'b1;
      wt();
      sda_low <= ~a;
      wt();
   endtask

   task automatic wr_byte(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      if (r !== 1'b0) nack_cnt++;
   endtask

   // last byte of a burst is answered with a nack
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      cond(1'b0);
      wr_byte({DEV_ADDR, 1'b0});
      wr_byte(a);
      wr_byte(d);
      cond(1'b1);
   endtask

   // n bytes, newest in the low byte; at the data port a word is always 3 bytes
   task automatic reg_read(input logic [7:0] a, input int n, output logic [23:0] v);
      logic [7:0] b;
      v = '0;
      cond(1'b0);
      wr_byte({DEV_ADDR, 1'b0});
      wr_byte(a);
      cond(1'b0);
      wr_byte({DEV_ADDR, 1'b1});
      for (int k = 0; k < n; k++) begin
         rd_byte(k == n - 1, b);
         v = {v[15:0], b};
      end
      cond(1'b1);
   endtask
endmodule

// [testbench/tsa_core_tb_top.sv]
/* tsa_core_tb_top: register-level tests of slope detection, flags and result words.
   Assumes tsa_host_model as the bus host and a pulled-up sda line. */
`timescale 1ns/1ps
module tsa_core_tb_top;
   import tsa_pkg::*;
   logic sys_clk, adc_clk, rst_b, adc_valid, conv_req, scl, sda_low, sda_out, sda_oe, irq_b;
   logic [15:0] adc_data;
   logic [23:0] v;
   wire sda;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int req_cnt = 0;
   logic conv_pin = 1'b1;
   // whole words: external trigger type, slope code and threshold code all checked
   logic [23:0] fexp [5] = '{24'h470064, 24'h57000A, 24'h59FFEC, 24'h450032, 24'hFFFFFF};

   // open drain with pull-up: any party pulling low wins
   assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // converter clock, phase unrelated to sys_clk
   initial begin
      adc_clk = 1'b0;
      #3.7;
      forever #7.5 adc_clk = ~adc_clk;
   end

   tsa_core #(.AUTO_PERIOD_CYC(200)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .adc_clk(adc_clk), .adc_valid(adc_valid), .adc_data(adc_data), .conv_req(conv_req),
      .external_convert_input(conv_pin), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq_b(irq_b));
   tsa_host_model i_host (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

   task automatic chk_reg(input string nm, input logic [23:0] exp, input logic [23:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_pin(input string nm, input logic exp);
      tests_run++;
      if (irq_b !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", nm, exp, irq_b);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one converter sample, then room for it to land in the FIFO
   task automatic sample(input logic [15:0] t);
      @(posedge adc_clk);
      adc_data <= t;
      adc_valid <= 1'b1;
      @(posedge adc_clk);
      adc_valid <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask

   // conv_req stands one cycle; count its pulses where they are settled
   always @(negedge sys_clk) begin
      if (conv_req === 1'b1) req_cnt++;
   end

   // a hung bus transfer would otherwise never end the run
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         $display("CHECK FAILED timeout expected finish seen hang");
         print_verdict();
      end
   end

   initial begin
      rst_b = 1'b0;
      adc_valid = 1'b0;
      adc_data = 16'h0000;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      i_host.reg_read(REG_FILT_CFG, 1, v);
      chk_reg("filter config reset", 24'h000000, v);
      i_host.reg_read(8'h3F, 1, v);
      chk_reg("unmapped read", 24'h000000, v);
      $display("test reset values done");
      // external trigger, both alarms enabled, 2-sample window
      i_host.reg_write(REG_PIN_CFG, 8'h80);
      i_host.reg_write(REG_IRQ_EN, 8'h30);
      i_host.reg_write(REG_RISE_LIM, 8'h02);
      i_host.reg_write(REG_FALL_LIM, 8'h02);
      i_host.reg_write(REG_FILT_CFG, 8'h08);
      i_host.reg_read(REG_FALL_LIM, 1, v);
      chk_reg("fall limit readback", 24'h000002, v);
      // alarm band 0x0040..0x0060, then one falling edge on the convert pin
      i_host.reg_write(REG_ALARM_HI_H, 8'h00);
      i_host.reg_write(REG_ALARM_HI_L, 8'h60);
      i_host.reg_write(REG_ALARM_LO_H, 8'h00);
      i_host.reg_write(REG_ALARM_LO_L, 8'h40);
      conv_pin <= 1'b0;
      repeat (8) @(posedge sys_clk);
      conv_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk_reg("convert requests", 24'h000001, 24'(req_cnt));
      sample(16'h0064);
      i_host.reg_read(REG_SLOPE_L, 1, v);
      chk_reg("slope before window", 24'h000000, v);
      sample(16'h006E);
      chk_pin("irq on rise", 1'b0);
      i_host.reg_read(REG_SLOPE_L, 1, v);
      chk_reg("slope rise", 24'h00000A, v);
      i_host.reg_read(REG_STATUS, 1, v);
      chk_reg("status rise", 24'h000010, v & 24'h000030);
      chk_pin("irq after status read", 1'b1);
      i_host.reg_read(REG_STATUS, 1, v);
      chk_reg("status cleared", 24'h000000, v & 24'h000030);
      $display("test rise done");
      // fall with only the rise interrupt enabled
      i_host.reg_write(REG_IRQ_EN, 8'h10);
      sample(16'h005A);
      chk_pin("irq fall masked", 1'b1);
      i_host.reg_read(REG_SLOPE_H, 2, v);
      chk_reg("slope fall", 24'h0001EC, v);
      i_host.reg_read(REG_STATUS, 1, v);
      chk_reg("status fall", 24'h000020, v & 24'h000030);
      $display("test fall done");
      // detection off: a steep drop must raise nothing
      i_host.reg_write(REG_FILT_CFG, 8'h00);
      sample(16'h0032);
      i_host.reg_read(REG_STATUS, 1, v);
      chk_reg("status disabled", 24'h000000, v & 24'h000030);
      for (int k = 0; k < 5; k++) begin
         i_host.reg_read(REG_FIFO_DATA, 3, v);
         chk_reg("fifo word", fexp[k], v);
      end
      chk_reg("target acks", 24'h000000, i_host.nack_cnt[23:0]);
      $display("test fifo done");
      // 17-sample window: slope held until full, then recomputed on each sample
      i_host.reg_write(REG_FILT_CFG, 8'h0C);
      for (int k = 0; k < 16; k++) sample(16'h0100 + 16'(k * 32));
      i_host.reg_read(REG_SLOPE_H, 2, v);
      chk_reg("slope held in window", 24'h0001EC, v);
      sample(16'h0300);
      i_host.reg_read(REG_SLOPE_L, 1, v);
      chk_reg("slope 17 samples", 24'h000020, v);
      sample(16'h0340);
      i_host.reg_read(REG_SLOPE_L, 1, v);
      chk_reg("slope recomputed", 24'h000022, v);
      $display("test window done");
      print_verdict();
   end
endmodule
